// [common/dbra_pkg.sv]
// package: debug register access command constants and types
package dbra_pkg;

    // ----------------------------------------------------------------
    // debug register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WR_UPPER = 8'h13;
    localparam logic [7:0] ADDR_WR_HIGH  = 8'h14;
    localparam logic [7:0] ADDR_WR_LOW   = 8'h15;
    localparam logic [7:0] ADDR_COMMAND  = 8'h16;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_RD_MEMORY_BASE_REGISTER_AF = 8'h00;
    localparam logic [7:0] CMD_RD_BC       = 8'h01;
    localparam logic [7:0] CMD_RD_DE       = 8'h02;
    localparam logic [7:0] CMD_RD_HL       = 8'h03;
    localparam logic [7:0] CMD_RD_IX       = 8'h04;
    localparam logic [7:0] CMD_RD_IY       = 8'h05;
    localparam logic [7:0] CMD_RD_SP       = 8'h06;
    localparam logic [7:0] CMD_RD_PC       = 8'h07;
    localparam logic [7:0] CMD_SET_LONG    = 8'h08;
    localparam logic [7:0] CMD_CLR_LONG    = 8'h09;
    localparam logic [7:0] CMD_EXCHANGE    = 8'h0a;
    localparam logic [7:0] CMD_RD_MEM      = 8'h0b;
    localparam logic [7:0] CMD_WR_MEMORY_BASE_REGISTER_AF = 8'h80;
    localparam logic [7:0] CMD_WR_BC       = 8'h81;
    localparam logic [7:0] CMD_WR_DE       = 8'h82;
    localparam logic [7:0] CMD_WR_HL       = 8'h83;
    localparam logic [7:0] CMD_WR_IX       = 8'h84;
    localparam logic [7:0] CMD_WR_IY       = 8'h85;
    localparam logic [7:0] CMD_WR_SP       = 8'h86;
    localparam logic [7:0] CMD_WR_PC       = 8'h87;
    localparam logic [7:0] CMD_WR_MEM      = 8'h8b;

    // ----------------------------------------------------------------
    // reset values and pc step
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [23:0] RST_WORD = 24'h000000;
    localparam logic [23:0] PC_STEP  = 24'h000001;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] high;
        logic [7:0] low;
    } dbra_triple_t;

    typedef struct packed {
        logic [7:0]   memory_base_register;
        logic [7:0]   acc;
        logic [7:0]   flags;
        dbra_triple_t bc;
        dbra_triple_t de;
        dbra_triple_t hl;
        dbra_triple_t ix;
        dbra_triple_t iy;
        logic [23:0]  sp_long;
        logic [15:0]  sp_short;
        logic [23:0]  pc;
        logic         long_mode;
    } dbra_cpu_t;

    typedef struct packed {
        logic [7:0]   acc;
        logic [7:0]   flags;
        dbra_triple_t bc;
        dbra_triple_t de;
        dbra_triple_t hl;
    } dbra_alt_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_MEM_RD   = 3'b010,
        ST_MEM_WR   = 3'b100
    } dbra_state_t;

endpackage

// [rtl/dbra_cmd.sv]
// debug register access command executor
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------------
// --------------------------------------------------------------------
module dbra_cmd (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // byte stream from the serial link front end
    input  wire logic                 xfer_start_in,
    input  wire logic [7:0]           xfer_addr_in,
    input  wire logic                 byte_valid_in,
    input  wire logic [7:0]           byte_data_in,
    // memory port
    output logic                      mem_rd_out,
    output logic                      mem_wr_out,
    output logic [23:0]               mem_addr_out,
    output logic [7:0]                mem_wdata_out,
    input  wire logic [7:0]           mem_rdata_in,
    input  wire logic                 mem_ack_in,
    // results and state
    output dbra_pkg::dbra_triple_t    rd_result_out,
    output dbra_pkg::dbra_cpu_t       cpu_regs_out,
    output logic                      busy_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]              addr;
        dbra_pkg::dbra_triple_t  operand;
        dbra_pkg::dbra_triple_t  result;
        dbra_pkg::dbra_cpu_t     cpu;
        dbra_pkg::dbra_alt_t     alt;
        dbra_pkg::dbra_state_t   state;
        logic                    mem_rd;
        logic                    mem_wr;
        logic [23:0]             mem_addr;
        logic [7:0]              mem_wdata;
    } dbra_regs_t;

    dbra_regs_t regs_ff;
    dbra_regs_t nxt_regs;

    // memory address depends on mode: short mode pages with memory_base_register
    function automatic logic [23:0] mem_address(
        input dbra_pkg::dbra_cpu_t c
    );
        mem_address = c.long_mode ? c.pc : {c.memory_base_register, c.pc[15:0]};
    endfunction

    function automatic logic [23:0] pc_next(input logic [23:0] pc);
        pc_next = pc + dbra_pkg::PC_STEP;
    endfunction

    logic       cmd_write;
    logic [7:0] cur_addr;

    always_comb begin
        nxt_regs  = regs_ff;
        cur_addr  = xfer_start_in ? xfer_addr_in : regs_ff.addr;
        cmd_write = 1'b0;
        if (xfer_start_in) begin
            nxt_regs.addr = xfer_addr_in;
        end
        // bytes arriving during a memory cycle are dropped; link must wait
        if (byte_valid_in && (regs_ff.state == dbra_pkg::ST_IDLE)) begin
            nxt_regs.addr = cur_addr + 8'h01;
            if (cur_addr == dbra_pkg::ADDR_WR_UPPER) begin
                nxt_regs.operand.upper = byte_data_in;
            end else if (cur_addr == dbra_pkg::ADDR_WR_HIGH) begin
                nxt_regs.operand.high = byte_data_in;
            end else if (cur_addr == dbra_pkg::ADDR_WR_LOW) begin
                nxt_regs.operand.low = byte_data_in;
            end else if (cur_addr == dbra_pkg::ADDR_COMMAND) begin
                cmd_write = 1'b1;
            end
        end
        if (cmd_write) begin
            case (byte_data_in)
                dbra_pkg::CMD_RD_MEMORY_BASE_REGISTER_AF: begin
                    nxt_regs.result = {regs_ff.cpu.memory_base_register,
                                       regs_ff.cpu.flags, regs_ff.cpu.acc};
                end
                dbra_pkg::CMD_RD_BC: nxt_regs.result = regs_ff.cpu.bc;
                dbra_pkg::CMD_RD_DE: nxt_regs.result = regs_ff.cpu.de;
                dbra_pkg::CMD_RD_HL: nxt_regs.result = regs_ff.cpu.hl;
                dbra_pkg::CMD_RD_IX: nxt_regs.result = regs_ff.cpu.ix;
                dbra_pkg::CMD_RD_IY: nxt_regs.result = regs_ff.cpu.iy;
                dbra_pkg::CMD_RD_SP: begin
                    nxt_regs.result = regs_ff.cpu.long_mode
                        ? regs_ff.cpu.sp_long
                        : {dbra_pkg::RST_BYTE, regs_ff.cpu.sp_short};
                end
                dbra_pkg::CMD_RD_PC: nxt_regs.result = regs_ff.cpu.pc;
                dbra_pkg::CMD_SET_LONG: nxt_regs.cpu.long_mode = 1'b1;
                dbra_pkg::CMD_CLR_LONG: nxt_regs.cpu.long_mode = 1'b0;
                dbra_pkg::CMD_EXCHANGE: begin
                    nxt_regs.alt = {regs_ff.cpu.acc, regs_ff.cpu.flags,
                                    regs_ff.cpu.bc, regs_ff.cpu.de,
                                    regs_ff.cpu.hl};
                    nxt_regs.cpu.acc   = regs_ff.alt.acc;
                    nxt_regs.cpu.flags = regs_ff.alt.flags;
                    nxt_regs.cpu.bc    = regs_ff.alt.bc;
                    nxt_regs.cpu.de    = regs_ff.alt.de;
                    nxt_regs.cpu.hl    = regs_ff.alt.hl;
                end
                dbra_pkg::CMD_RD_MEM: begin
                    nxt_regs.state    = dbra_pkg::ST_MEM_RD;
                    nxt_regs.mem_rd   = 1'b1;
                    nxt_regs.mem_addr = mem_address(regs_ff.cpu);
                end
                dbra_pkg::CMD_WR_MEMORY_BASE_REGISTER_AF: begin
                    nxt_regs.cpu.memory_base_register = regs_ff.operand.upper;
                    nxt_regs.cpu.flags = regs_ff.operand.high;
                    nxt_regs.cpu.acc   = regs_ff.operand.low;
                end
                dbra_pkg::CMD_WR_BC: nxt_regs.cpu.bc = regs_ff.operand;
                dbra_pkg::CMD_WR_DE: nxt_regs.cpu.de = regs_ff.operand;
                dbra_pkg::CMD_WR_HL: nxt_regs.cpu.hl = regs_ff.operand;
                dbra_pkg::CMD_WR_IX: nxt_regs.cpu.ix = regs_ff.operand;
                dbra_pkg::CMD_WR_IY: nxt_regs.cpu.iy = regs_ff.operand;
                dbra_pkg::CMD_WR_SP: begin
                    if (regs_ff.cpu.long_mode) begin
                        nxt_regs.cpu.sp_long = regs_ff.operand;
                    end else begin
                        nxt_regs.cpu.sp_short = regs_ff.operand[15:0];
                    end
                end
                dbra_pkg::CMD_WR_PC: nxt_regs.cpu.pc = regs_ff.operand;
                dbra_pkg::CMD_WR_MEM: begin
                    nxt_regs.state     = dbra_pkg::ST_MEM_WR;
                    nxt_regs.mem_wr    = 1'b1;
                    nxt_regs.mem_addr  = mem_address(regs_ff.cpu);
                    nxt_regs.mem_wdata = regs_ff.operand.low;
                end
                default: begin
                    nxt_regs.state = regs_ff.state;
                end
            endcase
        end
        // memory cycle completion
        case (regs_ff.state)
            dbra_pkg::ST_MEM_RD: begin
                if (mem_ack_in) begin
                    nxt_regs.result = {dbra_pkg::RST_BYTE,
                                       dbra_pkg::RST_BYTE, mem_rdata_in};
                    nxt_regs.cpu.pc = pc_next(regs_ff.cpu.pc);
                    nxt_regs.mem_rd = 1'b0;
                    nxt_regs.state  = dbra_pkg::ST_IDLE;
                end
            end
            dbra_pkg::ST_MEM_WR: begin
                if (mem_ack_in) begin
                    nxt_regs.cpu.pc = pc_next(regs_ff.cpu.pc);
                    nxt_regs.mem_wr = 1'b0;
                    nxt_regs.state  = dbra_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_regs.mem_rd = nxt_regs.mem_rd;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            regs_ff       <= '0;
            regs_ff.state <= dbra_pkg::ST_IDLE;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // result bytes
    assign rd_result_out = regs_ff.result;
    assign cpu_regs_out  = regs_ff.cpu;
    assign mem_rd_out    = regs_ff.mem_rd;
    assign mem_wr_out    = regs_ff.mem_wr;
    assign mem_addr_out  = regs_ff.mem_addr;
    assign mem_wdata_out = regs_ff.mem_wdata;
    assign busy_out      = (regs_ff.state != dbra_pkg::ST_IDLE);

endmodule
`default_nettype wire

// [verification/dbra_cmd_asserts.sv]
// checker: port-level properties of the debug command executor
`timescale 1ns/1ps
`default_nettype none
module dbra_cmd_asserts (
    // clock and reset
    input wire logic                   clk_in,
    input wire logic                   reset_n_in,
    // byte stream and memory port
    input wire logic                   xfer_start_in,
    input wire logic [7:0]             xfer_addr_in,
    input wire logic                   byte_valid_in,
    input wire logic [7:0]             byte_data_in,
    input wire logic                   mem_rd_out,
    input wire logic                   mem_wr_out,
    input wire logic [23:0]            mem_addr_out,
    input wire logic [7:0]             mem_wdata_out,
    input wire logic [7:0]             mem_rdata_in,
    input wire logic                   mem_ack_in,
    // results and state
    input wire dbra_pkg::dbra_triple_t rd_result_out,
    input wire dbra_pkg::dbra_cpu_t    cpu_regs_out,
    input wire logic                   busy_out
);
    // only the first byte of a transfer addressed straight to the command register counts
    logic go;
    assign go = xfer_start_in && byte_valid_in && !busy_out
                && xfer_addr_in == 8'h16;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_set_long: assert property (
        go && byte_data_in == 8'h08 |=> cpu_regs_out.long_mode)
        else $error("long mode not set");
    a_clr_long: assert property (
        go && byte_data_in == 8'h09 |=> !cpu_regs_out.long_mode)
        else $error("long mode not cleared");
    a_read_pc: assert property (
        go && byte_data_in == 8'h07 |=> rd_result_out == $past(cpu_regs_out.pc))
        else $error("pc read wrong");
    a_read_bc: assert property (
        go && byte_data_in == 8'h01 |=> rd_result_out == $past(cpu_regs_out.bc))
        else $error("bc read wrong");
    a_rsvd_quiet: assert property (
        go && byte_data_in == 8'h88
        |=> $stable(cpu_regs_out) && $stable(rd_result_out))
        else $error("reserved code changed state");
    a_mem_start: assert property (
        go && byte_data_in == 8'h0b |=> mem_rd_out && busy_out)
        else $error("memory read not started");
    a_rd_hold: assert property (
        mem_rd_out && !mem_ack_in |=> mem_rd_out)
        else $error("read request dropped early");
    a_rd_done: assert property (
        mem_rd_out && mem_ack_in |=> rd_result_out == {16'h0000,
        $past(mem_rdata_in)}
        && cpu_regs_out.pc == $past(cpu_regs_out.pc) + 24'h000001)
        else $error("memory read result or pc wrong");
    a_wr_addr: assert property (
        mem_wr_out |-> mem_addr_out == (cpu_regs_out.long_mode ? cpu_regs_out.pc
        : {cpu_regs_out.memory_base_register, cpu_regs_out.pc[15:0]}))
        else $error("memory write address wrong");
    a_wr_step: assert property (
        mem_wr_out && mem_ack_in
        |=> cpu_regs_out.pc == $past(cpu_regs_out.pc) + 24'h000001)
        else $error("pc not stepped after write");
endmodule
bind dbra_cmd dbra_cmd_asserts u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .xfer_start_in(xfer_start_in), .xfer_addr_in(xfer_addr_in),
    .byte_valid_in(byte_valid_in), .byte_data_in(byte_data_in),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in),
    .rd_result_out(rd_result_out), .cpu_regs_out(cpu_regs_out),
    .busy_out(busy_out));
`default_nettype wire

// [verification/dbra_mem_model.sv]
// partner: memory answering the executor's memory port
`timescale 1ns/1ps
`default_nettype none
module dbra_mem_model (
    input  wire logic        clk_in,
    input  wire logic        mem_rd_in,
    input  wire logic        mem_wr_in,
    input  wire logic [23:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic [3:0]  wait_in,
    output logic [7:0]       mem_rdata_out,
    output logic             mem_ack_out
);
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        mem_ack_out = 1'b0;
        mem_rdata_out = 8'h00;
        forever begin
            @(negedge clk_in);
            if (mem_rd_in || mem_wr_in) begin
                repeat (wait_in) @(negedge clk_in);
                if (mem_wr_in) mem[mem_addr_in[7:0]] = mem_wdata_in;
                if (mem_rd_in) mem_rdata_out = mem[mem_addr_in[7:0]];
                mem_ack_out = 1'b1;
                @(negedge clk_in);
                mem_ack_out = 1'b0;
                // after a read the released line shows the inverse, never a stale byte
                mem_rdata_out = ~mem_rdata_out;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/dbra_cmd_tb_top.sv]
// testbench: command executor driven through its byte stream
`timescale 1ns/1ps
`default_nettype none
module dbra_cmd_tb_top;
    logic                   clk_in, reset_n_in, xfer_start_in, byte_valid_in;
    logic                   mem_rd_out, mem_wr_out, mem_ack_in, busy_out;
    logic [7:0]             xfer_addr_in, byte_data_in, mem_wdata_out, mem_rdata_in;
    logic [23:0]            mem_addr_out;
    logic [3:0]             mem_wait;
    dbra_pkg::dbra_triple_t rd_result_out;
    dbra_pkg::dbra_cpu_t    cpu_regs_out;
    int                     err_total, samples_checked;
    logic [7:0]             rsvd [4] = '{8'h88, 8'h89, 8'h8a, 8'hff};
    dbra_cmd u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .xfer_start_in(xfer_start_in), .xfer_addr_in(xfer_addr_in),
        .byte_valid_in(byte_valid_in), .byte_data_in(byte_data_in),
        .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in),
        .rd_result_out(rd_result_out), .cpu_regs_out(cpu_regs_out),
        .busy_out(busy_out));
    dbra_mem_model u_mem (.clk_in(clk_in), .mem_rd_in(mem_rd_out),
        .mem_wr_in(mem_wr_out), .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .wait_in(mem_wait),
        .mem_rdata_out(mem_rdata_in), .mem_ack_out(mem_ack_in));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic put(input logic s, input logic [7:0] a, input logic [7:0] d);
        xfer_start_in = s;
        xfer_addr_in = a;
        byte_valid_in = 1'b1;
        byte_data_in = d;
        @(negedge clk_in);
    endtask
    // idle a cycle, then wait out any memory cycle under a bound
    task automatic idle();
        xfer_start_in = 1'b0;
        byte_valid_in = 1'b0;
        @(negedge clk_in);
        for (int i = 0; i < 50 && busy_out !== 1'b0; i++) @(negedge clk_in);
        if (busy_out !== 1'b0) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     busy_out, 1'b0);
        end
    endtask
    // operand and command in one stream, relying on address advance
    task automatic wr_cmd(input logic [23:0] op, input logic [7:0] c);
        put(1'b1, 8'h13, op[23:16]);
        put(1'b0, 8'h00, op[15:8]);
        put(1'b0, 8'h00, op[7:0]);
        put(1'b0, 8'h00, c);
        idle();
    endtask
    task automatic cmd(input logic [7:0] c);
        put(1'b1, 8'h16, c);
        idle();
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        test_done();
    end
    initial begin
        {reset_n_in, xfer_start_in, byte_valid_in} = 3'b000;
        {xfer_addr_in, byte_data_in, mem_wait} = 20'h00002;
        repeat (5) @(negedge clk_in);
        reset_n_in = 1'b1;
        for (int i = 1; i < 6; i++) wr_cmd(24'h102030 + 24'(i), 8'h80 + 8'(i));
        chk(cpu_regs_out.bc, 24'h102031);
        for (int i = 1; i < 6; i++) begin
            cmd(8'(i));
            chk(rd_result_out, 24'h102030 + 24'(i));
        end
        wr_cmd(24'ha1b2c3, 8'h80);
        chk({cpu_regs_out.memory_base_register, cpu_regs_out.flags, cpu_regs_out.acc},
            24'ha1b2c3);
        cmd(8'h00);
        chk(rd_result_out, 24'ha1b2c3);
        wr_cmd(24'h123456, 8'h87);
        cmd(8'h07);
        chk(rd_result_out, 24'h123456);
        cmd(8'h09);
        wr_cmd(24'habcdef, 8'h86);
        chk(24'(cpu_regs_out.sp_short), 24'h00cdef);
        cmd(8'h06);
        chk(rd_result_out, 24'h00cdef);
        cmd(8'h08);
        chk(24'(cpu_regs_out.long_mode), 24'h000001);
        wr_cmd(24'h654321, 8'h86);
        cmd(8'h06);
        chk(rd_result_out, 24'h654321);
        cmd(8'h0a);
        cmd(8'h01);
        chk(rd_result_out, 24'h000000);
        cmd(8'h0a);
        cmd(8'h01);
        chk(rd_result_out, 24'h102031);
        foreach (rsvd[i]) begin
            cmd(rsvd[i]);
            chk(rd_result_out, 24'h102031);
            chk(cpu_regs_out.pc, 24'h123456);
        end
        // slow memory read; a byte sent meanwhile must be dropped
        mem_wait = 4'h5;
        wr_cmd(24'h000010, 8'h87);
        put(1'b1, 8'h16, 8'h0b);
        xfer_start_in = 1'b0;
        byte_valid_in = 1'b0;
        @(negedge clk_in);
        put(1'b1, 8'h16, 8'h09);
        idle();
        chk(rd_result_out, 24'h00004a);
        chk(cpu_regs_out.pc, 24'h000011);
        chk(24'(cpu_regs_out.long_mode), 24'h000001);
        mem_wait = 4'h0;
        wr_cmd(24'hffff77, 8'h8b);
        chk(cpu_regs_out.pc, 24'h000012);
        wr_cmd(24'h000011, 8'h87);
        cmd(8'h0b);
        chk(rd_result_out, 24'h000077);
        // short mode pages the write address with the memory base
        cmd(8'h09);
        wr_cmd(24'hffff55, 8'h8b);
        chk(mem_addr_out, 24'ha10012);
        chk({16'h0000, mem_wdata_out}, 24'h000055);
        chk(cpu_regs_out.pc, 24'h000013);
        test_done();
    end
endmodule
`default_nettype wire
